// file: hdl/fsp_pkg.sv
// Shared constants, types and decode helpers for the flash sequencer.
// Assumes a 14-bit byte address space and an 8-bit data path.
package fsp_pkg;

  localparam int ADDR_W = 14;
  localparam int DATA_W = 8;

  // Register and window addresses
  localparam logic [13:0] FLASH_OPTIONS_WORKING_ADDR     = 14'h0210;
  localparam logic [13:0] FLASH_OPTIONS_NONVOLATILE_ADDR = 14'h3FFC;
  localparam logic [13:0] FLASH_CONTROL_ADDR             = 14'h0211;
  localparam logic [13:0] PAGE_SELECT_ADDR               = 14'h001F;
  localparam logic [13:0] INDEXED_DATA_ADDR              = 14'h000E;
  localparam logic [13:0] WINDOW_LO_ADDR                 = 14'h00C0;
  localparam logic [13:0] WINDOW_HI_ADDR                 = 14'h00FF;
  localparam logic [13:0] FLASH_LO_ADDR                  = 14'h2000;
  localparam logic [13:0] FLASH_HI_ADDR                  = 14'h3FFF;

  // Field positions
  localparam int HIGH_VOLTAGE_ENABLE_BIT   = 3;
  localparam int MASS_ERASE_SELECT_BIT     = 2;
  localparam int PROGRAM_SELECT_BIT        = 0;
  localparam int SECURITY_DISABLE_CODE_BIT = 0;
  localparam logic [7:0] FLASH_CONTROL_MASK = 8'h0D;

  // Reset values
  localparam logic [7:0] FLASH_CONTROL_RST         = 8'h00;
  localparam logic [7:0] PAGE_SELECT_RST           = 8'h00;
  localparam logic [7:0] FLASH_OPTIONS_WORKING_RST = 8'h00;

  // Cycles the mode pin synchroniser needs before it is trusted
  localparam logic [1:0] BOOT_SYNC_CYCLES = 2'h3;

  typedef enum logic [1:0] {
    BOOT_SYNC = 2'b00,
    BOOT_READ = 2'b01,
    BOOT_CAPT = 2'b10,
    BOOT_DONE = 2'b11
  } fsp_boot_t;

  function automatic logic is_flash(input logic [13:0] a);
    is_flash = (a >= FLASH_LO_ADDR) && (a <= FLASH_HI_ADDR);
  endfunction

endpackage

// file: hdl/fsp_link_if.sv
// Carrier between the flash controller core, the page mapper and the
// option loader. All members share the controller's clock.
`timescale 1ns/100ps
interface fsp_link_if;
  logic [13:0] log_addr;
  logic [7:0]  page;
  logic [7:0]  index_x;
  logic [13:0] phys_addr;
  logic        idx_hit;
  logic        boot_rd;
  logic        boot_capture;
  logic        boot_done;
  logic        mode_normal;

  modport core (output log_addr, page, index_x,
                input  phys_addr, idx_hit, boot_rd, boot_capture,
                       boot_done, mode_normal);
  modport mapper (input log_addr, page, index_x,
                  output phys_addr, idx_hit);
  modport loader (output boot_rd, boot_capture, boot_done, mode_normal);
endinterface

// file: hdl/fsp_page_map.sv
// Combinational address translation for the paging window and the
// indexed-data location. Assumes the core registers its result.
`timescale 1ns/100ps
module fsp_page_map (
  fsp_link_if.mapper lk
);
  import fsp_pkg::*;

  function automatic logic [13:0] window_map(input logic [13:0] a,
                                             input logic [7:0]  pg);
    if (a >= WINDOW_LO_ADDR && a <= WINDOW_HI_ADDR) begin
      window_map = {pg, a[5:0]};
    end else begin
      window_map = a;
    end
  endfunction

  // Indexed location redirects to the address held in X, which may
  // itself land in the window; window hits never redirect again
  always_comb begin
    lk.idx_hit = (lk.log_addr == INDEXED_DATA_ADDR);
    if (lk.idx_hit) begin
      lk.phys_addr = window_map({6'h00, lk.index_x}, lk.page);
    end else begin
      lk.phys_addr = window_map(lk.log_addr, lk.page);
    end
  end

endmodule

// file: hdl/fsp_boot_loader.sv
// Reset-time sequencer: settles the mode pin, then asks the core for
// one read of the nonvolatile option byte and marks boot complete.
`timescale 1ns/100ps
module fsp_boot_loader (
  input  wire logic  mclk,
  input  wire logic  rst_n,
  input  wire logic  mode_select_pin,
  fsp_link_if.loader lk
);
  import fsp_pkg::*;

  fsp_boot_t  state_reg;
  fsp_boot_t  state_next;
  logic [2:0] mode_sync_reg;
  logic [1:0] wait_reg;
  logic       mode_normal_reg;
  logic       done_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_sync_reg <= 3'h0;
    end else begin
      mode_sync_reg <= {mode_sync_reg[1:0], mode_select_pin};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg <= 2'h0;
    end else if (state_reg == BOOT_SYNC && wait_reg != BOOT_SYNC_CYCLES) begin
      wait_reg <= wait_reg + 2'h1;
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      BOOT_SYNC: begin
        if (wait_reg == BOOT_SYNC_CYCLES &&
            mode_sync_reg[1] == mode_sync_reg[2]) begin
          state_next = BOOT_READ;
        end
      end
      BOOT_READ: state_next = BOOT_CAPT;
      BOOT_CAPT: state_next = BOOT_DONE;
      BOOT_DONE: state_next = BOOT_DONE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= BOOT_SYNC;
    end else begin
      state_reg <= state_next;
    end
  end

  // Boot complete kept in its own flop so the top output is registered
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (state_next == BOOT_DONE);
    end
  end

  // High pin during reset means normal operating mode
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_normal_reg <= 1'b0;
    end else if (state_reg == BOOT_READ) begin
      mode_normal_reg <= mode_sync_reg[2];
    end
  end

  assign lk.boot_rd      = (state_reg == BOOT_READ);
  assign lk.boot_capture = (state_reg == BOOT_CAPT);
  assign lk.boot_done    = done_reg;
  assign lk.mode_normal  = mode_normal_reg;

endmodule

// file: hdl/fsp_flash_ctrl.sv
// Flash control core: control and paging registers, option byte load,
// security gating and address translation for the CPU and debug paths.
// Assumes one access per cycle, rd and wr never together, and memory
// that answers mem_rd combinationally in the cycle it is presented.
//
// Functional notes
// - Only RAM code or debug commands may program or erase flash.
// - Secure flash reads via debug path or with pin enable return zero.
// - Every reset copies the option byte into the working options register.
// - Security code 1 is unsecure; 0 secures the part from next reset.
// - Only mass erase then reset removes security; part then boots unsecure.
// - Normal mode boot while secured clears pin enable, blocks debug traffic.
// - Options register bits 7 to 1 read zero; bit 0 is security code.
// - Options register is read-only; writes are ignored.
// - High voltage enable sets only after program or mass select and latch.
// - Control bit 2 selects mass erase, read and write.
// - Program select and mass select are never both one.
// - While secured, writes to program select have no effect.
// - A 64-byte window is redirected to the page-selected block.
// - Page bits form address 13:6, window offset forms address 5:0.
// - Page zero reaches 0x00-0x3F, including the page select register.
// - Direct access to 0x000E goes to the location held in X.
`timescale 1ns/100ps
module fsp_flash_ctrl (
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  input  wire logic                          mode_select_pin,
  input  wire logic [fsp_pkg::ADDR_W-1:0]    bus_addr,
  input  wire logic                          bus_rd,
  input  wire logic                          bus_wr,
  input  wire logic [fsp_pkg::DATA_W-1:0]    bus_wdata,
  input  wire logic                          bus_debug,
  input  wire logic                          bus_fetch_flash,
  input  wire logic [fsp_pkg::DATA_W-1:0]    index_x,
  input  wire logic [fsp_pkg::DATA_W-1:0]    mem_rdata,
  input  wire logic                          dbg_pe_wr,
  input  wire logic                          dbg_pe_wdata,
  output logic      [fsp_pkg::DATA_W-1:0]    bus_rdata,
  output logic                               bus_rvalid,
  output logic      [fsp_pkg::ADDR_W-1:0]    mem_addr,
  output logic                               mem_rd,
  output logic                               mem_wr,
  output logic      [fsp_pkg::DATA_W-1:0]    mem_wdata,
  output logic                               high_voltage_enable,
  output logic                               mass_erase_select,
  output logic                               program_select,
  output logic                               security_engaged,
  output logic                               debug_pin_enable,
  output logic                               debug_blocked,
  output logic                               boot_done
);
  import fsp_pkg::*;

  localparam int HV = HIGH_VOLTAGE_ENABLE_BIT;
  localparam int ME = MASS_ERASE_SELECT_BIT;
  localparam int PS = PROGRAM_SELECT_BIT;
  localparam int SC = SECURITY_DISABLE_CODE_BIT;

  fsp_link_if lk ();

  fsp_page_map u_map (
    .lk (lk)
  );

  fsp_boot_loader u_boot (
    .mclk            (mclk),
    .rst_n           (rst_n),
    .mode_select_pin (mode_select_pin),
    .lk              (lk)
  );

  logic [7:0]  flash_control_reg;
  logic [7:0]  flash_control_next;
  logic [7:0]  page_select_reg;
  logic [7:0]  flash_options_working_reg;
  logic        security_engaged_reg;
  logic        debug_pin_enable_reg;
  logic        debug_blocked_reg;
  logic        armed_reg;
  logic        armed_next;
  logic [13:0] mem_addr_reg;
  logic        mem_rd_reg;
  logic        mem_wr_reg;
  logic [7:0]  mem_wdata_reg;
  logic        rd_pend_reg;
  logic        rd_zero_reg;
  logic        rd_local_reg;
  logic [7:0]  local_data_reg;
  logic [7:0]  bus_rdata_reg;
  logic        bus_rvalid_reg;

  logic [13:0] phys;
  logic        hit_fc;
  logic        hit_ps;
  logic        hit_opt;
  logic        hit_local;
  logic        hit_flash;
  logic        req_ok;
  logic        rd_block;
  logic        flash_wr_ok;
  logic        flash_wr_acc;
  logic        fc_wr;
  logic        ps_wr;
  logic        mass_w;
  logic        pgm_w;
  logic [7:0]  local_data;

  assign lk.log_addr = bus_addr;
  assign lk.page     = page_select_reg;
  assign lk.index_x  = index_x;

  // Request decode on the translated address
  always_comb begin
    phys      = lk.phys_addr;
    hit_fc    = (phys == FLASH_CONTROL_ADDR);
    hit_ps    = (phys == PAGE_SELECT_ADDR);
    hit_opt   = (phys == FLASH_OPTIONS_WORKING_ADDR);
    hit_local = hit_fc | hit_ps | hit_opt;
    hit_flash = is_flash(phys);
    req_ok    = lk.boot_done & ~(bus_debug & debug_blocked_reg);
    rd_block  = hit_flash & security_engaged_reg &
                (bus_debug | debug_pin_enable_reg);
    flash_wr_ok = (flash_control_reg[PS] | flash_control_reg[ME]) &
                  ~bus_fetch_flash;
    flash_wr_acc = req_ok & bus_wr & hit_flash & flash_wr_ok;
    fc_wr     = req_ok & bus_wr & hit_fc & ~bus_fetch_flash;
    ps_wr     = req_ok & bus_wr & hit_ps;
  end

  // Control register update; no delay is timed here
  always_comb begin
    flash_control_next = flash_control_reg;
    mass_w = bus_wdata[ME];
    pgm_w  = security_engaged_reg ? flash_control_reg[PS]
                                  : bus_wdata[PS];
    if (fc_wr) begin
      if (!(mass_w && pgm_w)) begin
        flash_control_next[ME] = mass_w;
        flash_control_next[PS] = pgm_w;
      end
      flash_control_next[HV] = bus_wdata[HV] &
        (flash_control_reg[HV] |
         ((flash_control_reg[PS] | flash_control_reg[ME]) &
          armed_reg));
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flash_control_reg <= FLASH_CONTROL_RST;
    end else begin
      flash_control_reg <= flash_control_next & FLASH_CONTROL_MASK;
    end
  end

  // Latch write seen since select was raised; a new latch wins
  always_comb begin
    armed_next = flash_wr_acc |
                 (armed_reg & (flash_control_next[PS] |
                               flash_control_next[ME]));
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= armed_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      page_select_reg <= PAGE_SELECT_RST;
    end else if (ps_wr) begin
      page_select_reg <= bus_wdata;
    end
  end

  // Option byte load; writes to the options register never land here
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flash_options_working_reg <= FLASH_OPTIONS_WORKING_RST;
      security_engaged_reg      <= 1'b1;
      debug_blocked_reg         <= 1'b0;
    end else if (lk.boot_capture) begin
      flash_options_working_reg <= {7'h00, mem_rdata[SC]};
      security_engaged_reg      <= ~mem_rdata[SC];
      debug_blocked_reg         <= lk.mode_normal & ~mem_rdata[SC];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      debug_pin_enable_reg <= 1'b0;
    end else if (lk.boot_capture) begin
      debug_pin_enable_reg <= ~(lk.mode_normal & ~mem_rdata[SC]);
    end else if (dbg_pe_wr && lk.boot_done && !debug_blocked_reg) begin
      debug_pin_enable_reg <= dbg_pe_wdata;
    end
  end

  // Memory port: option byte fetch during boot, translated traffic after
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr_reg  <= 14'h0000;
      mem_rd_reg    <= 1'b0;
      mem_wr_reg    <= 1'b0;
      mem_wdata_reg <= 8'h00;
    end else if (!lk.boot_done) begin
      mem_addr_reg  <= FLASH_OPTIONS_NONVOLATILE_ADDR;
      mem_rd_reg    <= lk.boot_rd;
      mem_wr_reg    <= 1'b0;
    end else begin
      mem_addr_reg  <= phys;
      mem_rd_reg    <= bus_rd & req_ok & ~hit_local & ~rd_block;
      mem_wr_reg    <= bus_wr & req_ok & ~hit_local &
                       (~hit_flash | flash_wr_ok);
      mem_wdata_reg <= bus_wdata;
    end
  end

  always_comb begin
    local_data = 8'h00;
    if (hit_fc) begin
      local_data = flash_control_reg & FLASH_CONTROL_MASK;
    end else if (hit_ps) begin
      local_data = page_select_reg;
    end else if (hit_opt) begin
      local_data = flash_options_working_reg;
    end
  end

  // Read answer two edges after the request
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend_reg    <= 1'b0;
      rd_zero_reg    <= 1'b0;
      rd_local_reg   <= 1'b0;
      local_data_reg <= 8'h00;
    end else begin
      rd_pend_reg    <= bus_rd & lk.boot_done;
      rd_zero_reg    <= rd_block | (bus_debug & debug_blocked_reg);
      rd_local_reg   <= hit_local;
      local_data_reg <= local_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rvalid_reg <= 1'b0;
      bus_rdata_reg  <= 8'h00;
    end else begin
      bus_rvalid_reg <= rd_pend_reg;
      if (!rd_pend_reg || rd_zero_reg) begin
        bus_rdata_reg <= 8'h00;
      end else if (rd_local_reg) begin
        bus_rdata_reg <= local_data_reg;
      end else begin
        bus_rdata_reg <= mem_rdata;
      end
    end
  end

  assign bus_rdata           = bus_rdata_reg;
  assign bus_rvalid          = bus_rvalid_reg;
  assign mem_addr            = mem_addr_reg;
  assign mem_rd              = mem_rd_reg;
  assign mem_wr              = mem_wr_reg;
  assign mem_wdata           = mem_wdata_reg;
  assign high_voltage_enable = flash_control_reg[HV];
  assign mass_erase_select   = flash_control_reg[ME];
  assign program_select      = flash_control_reg[PS];
  assign security_engaged    = security_engaged_reg;
  assign debug_pin_enable    = debug_pin_enable_reg;
  assign debug_blocked       = debug_blocked_reg;
  assign boot_done           = lk.boot_done;

  opt_frozen_a: assert property (@(posedge mclk) disable iff (!rst_n)
    lk.boot_done |=> $stable(flash_options_working_reg))
    else $error("options register changed after boot");

  opt_unused_a: assert property (@(posedge mclk) disable iff (!rst_n)
    flash_options_working_reg[7:1] == 7'h00)
    else $error("unused option bits not zero");

  select_excl_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !(flash_control_reg[PS] && flash_control_reg[ME]))
    else $error("program and mass select both set");

  pgm_secure_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (security_engaged_reg && fc_wr) |=> $stable(flash_control_reg[PS]))
    else $error("program select changed while secure");

  hv_guard_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(flash_control_reg[HV]) |->
      $past(armed_reg) &&
      ($past(flash_control_reg[PS]) || $past(flash_control_reg[ME])))
    else $error("high voltage set without armed select");

  secure_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (lk.boot_done && bus_rd && rd_block) |=>
      !mem_rd_reg ##1 (bus_rvalid_reg && bus_rdata_reg == 8'h00))
    else $error("secure flash read not blocked");

  flash_fetch_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (lk.boot_done && bus_wr && bus_fetch_flash && hit_flash) |=>
      !mem_wr_reg && $stable(flash_control_reg))
    else $error("flash-resident code reached the array");

  boot_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
    lk.boot_capture |->
      mem_rd_reg && mem_addr_reg == FLASH_OPTIONS_NONVOLATILE_ADDR ##1
      flash_options_working_reg == {7'h00, $past(mem_rdata[SC])})
    else $error("option byte not copied at boot");

  normal_lock_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (lk.boot_capture && lk.mode_normal && !mem_rdata[SC]) |=>
      debug_blocked_reg && !debug_pin_enable_reg && security_engaged_reg)
    else $error("secured normal boot left debug open");

  indexed_map_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (lk.boot_done && bus_rd && bus_addr == INDEXED_DATA_ADDR &&
     index_x < 8'hC0) |=> mem_addr_reg == {6'h00, $past(index_x)})
    else $error("indexed location not redirected through X");

endmodule

// file: bench/tb_top.sv
// Self-checking bench for the flash control core: drives the CPU and
// debug bus, plays the memory behind mem_addr and checks the answers.
// Assumes reads answer one edge after the request edge.
`timescale 1ns/100ps
module tb_top;
  import fsp_pkg::*;
  logic        mclk, rst_n, mode_select_pin;
  logic [13:0] bus_addr, mem_addr, seen_addr;
  logic        bus_rd, bus_wr, bus_debug, bus_fetch_flash;
  logic [7:0]  bus_wdata, index_x, mem_rdata, bus_rdata, mem_wdata;
  logic        dbg_pe_wr, dbg_pe_wdata, bus_rvalid, mem_rd, mem_wr;
  logic        high_voltage_enable, mass_erase_select, program_select;
  logic        security_engaged, debug_pin_enable, debug_blocked;
  logic        boot_done, seen_strobe;
  logic [7:0]  nv_opt, rd_data;
  logic [7:0]  pg [4];
  logic [7:0]  off [4];
  int          n_fail, compares, cyc, i;

  fsp_flash_ctrl DUT (
    .mclk(mclk), .rst_n(rst_n), .mode_select_pin(mode_select_pin),
    .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
    .bus_wdata(bus_wdata), .bus_debug(bus_debug),
    .bus_fetch_flash(bus_fetch_flash), .index_x(index_x),
    .mem_rdata(mem_rdata), .dbg_pe_wr(dbg_pe_wr),
    .dbg_pe_wdata(dbg_pe_wdata), .bus_rdata(bus_rdata),
    .bus_rvalid(bus_rvalid), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .high_voltage_enable(high_voltage_enable),
    .mass_erase_select(mass_erase_select),
    .program_select(program_select),
    .security_engaged(security_engaged),
    .debug_pin_enable(debug_pin_enable), .debug_blocked(debug_blocked),
    .boot_done(boot_done)
  );

  // Memory answers only while read; otherwise a changing pattern
  assign mem_rdata = !mem_rd ? (8'hA5 ^ cyc[7:0]) :
                     (mem_addr == 14'h3FFC) ? nv_opt :
                     (mem_addr[7:0] ^ 8'h3C);

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    @(negedge mclk);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge mclk);
    bus_wr = 1'b0;
    seen_strobe = mem_wr;
    seen_addr = mem_addr;
  endtask

  task automatic rd(input logic [13:0] a);
    @(negedge mclk);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge mclk);
    bus_rd = 1'b0;
    seen_strobe = mem_rd;
    seen_addr = mem_addr;
    @(negedge mclk);
    rd_data = bus_rdata;
    check(16'(bus_rvalid), 16'h0001);
  endtask

  task automatic rdc(input logic [13:0] a, input logic [7:0] exp);
    rd(a);
    check(16'(rd_data), 16'(exp));
  endtask

  task automatic boot(input logic [7:0] nv, input logic pin_hi);
    int k;
    @(negedge mclk);
    rst_n = 1'b0;
    nv_opt = nv;
    mode_select_pin = pin_hi;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    for (k = 0; k < 20 && boot_done !== 1'b1; k++) @(negedge mclk);
    check(16'(boot_done), 16'h0001);
  endtask

  initial begin
    rst_n = 1'b0;
    mode_select_pin = 1'b1;
    bus_addr = 14'h0000;
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    bus_wdata = 8'h00;
    bus_debug = 1'b0;
    bus_fetch_flash = 1'b0;
    index_x = 8'h00;
    dbg_pe_wr = 1'b0;
    dbg_pe_wdata = 1'b0;
    nv_opt = 8'hFF;
    cyc = 0;
    n_fail = 0;
    compares = 0;
    pg = '{8'h00, 8'h01, 8'h80, 8'hFF};
    off = '{8'h0E, 8'h3F, 8'h10, 8'h3B};
    // Unsecure boot, options and control register basics
    boot(8'hFF, 1'b1);
    check(16'(security_engaged), 16'h0000);
    check(16'(debug_pin_enable), 16'h0001);
    rdc(14'h0210, 8'h01);
    wr(14'h0210, 8'hFE);
    rdc(14'h0210, 8'h01);
    rdc(14'h0211, 8'h00);
    rdc(14'h001F, 8'h00);
    wr(14'h0211, 8'h01);
    check(16'(program_select), 16'h0001);
    wr(14'h0211, 8'h05);
    rdc(14'h0211, 8'h01);
    wr(14'h0211, 8'h00);
    wr(14'h0211, 8'h04);
    rdc(14'h0211, 8'h04);
    wr(14'h0211, 8'h0C);
    rdc(14'h0211, 8'h04);
    $display("test control done");
    // Mass erase flow, flash-fetched code refused
    wr(14'h001F, 8'h80);
    bus_fetch_flash = 1'b1;
    wr(14'h00C5, 8'h77);
    check(16'(seen_strobe), 16'h0000);
    wr(14'h0211, 8'h0C);
    check(16'(high_voltage_enable), 16'h0000);
    bus_fetch_flash = 1'b0;
    wr(14'h00C5, 8'h77);
    check(16'(seen_strobe), 16'h0001);
    check(16'(seen_addr), 16'h2005);
    check(16'(mem_wdata), 16'h0077);
    wr(14'h0211, 8'h0C);
    check(16'(high_voltage_enable), 16'h0001);
    repeat (50) @(negedge mclk);
    check(16'(high_voltage_enable), 16'h0001);
    check(16'(mass_erase_select), 16'h0001);
    wr(14'h0211, 8'h08);
    rdc(14'h0211, 8'h08);
    wr(14'h0211, 8'h00);
    rdc(14'h0211, 8'h00);
    // Row programming
    wr(14'h0211, 8'h01);
    wr(14'h00C0, 8'h5A);
    check(16'(seen_addr), 16'h2000);
    wr(14'h0211, 8'h09);
    check(16'(high_voltage_enable), 16'h0001);
    wr(14'h0211, 8'h08);
    wr(14'h0211, 8'h00);
    $display("test erase done");
    // Paging window and indexed-data redirect
    for (i = 0; i < 4; i++) begin
      wr(14'h001F, pg[i]);
      rd(14'h00C0 | 14'(off[i]));
      check(16'(seen_addr), 16'({pg[i], off[i][5:0]}));
      check(16'(rd_data), 16'(off[i] ^ {pg[i][1:0], 6'h00} ^ 8'h3C));
    end
    wr(14'h001F, 8'h01);
    index_x = 8'h30;
    rd(14'h000E);
    check(16'(seen_addr), 16'h0030);
    index_x = 8'hC5;
    rd(14'h000E);
    check(16'(seen_addr), 16'h0045);
    $display("test paging done");
    // Secure boot in normal mode, then erase and reset to unsecure
    boot(8'hFE, 1'b1);
    check(16'(security_engaged), 16'h0001);
    check(16'(debug_pin_enable), 16'h0000);
    check(16'(debug_blocked), 16'h0001);
    rdc(14'h0210, 8'h00);
    wr(14'h0211, 8'h01);
    check(16'(program_select), 16'h0000);
    bus_debug = 1'b1;
    rdc(14'h0030, 8'h00);
    bus_debug = 1'b0;
    wr(14'h001F, 8'h80);
    rdc(14'h00C4, 8'h38);
    wr(14'h0211, 8'h04);
    wr(14'h00C0, 8'h11);
    check(16'(seen_strobe), 16'h0001);
    wr(14'h0211, 8'h0C);
    check(16'(high_voltage_enable), 16'h0001);
    wr(14'h0211, 8'h08);
    wr(14'h0211, 8'h00);
    boot(8'hFF, 1'b1);
    check(16'(security_engaged), 16'h0000);
    $display("test secure normal done");
    // Secure boot in debug mode: flash reads gated
    boot(8'hFE, 1'b0);
    check(16'(debug_pin_enable), 16'h0001);
    wr(14'h001F, 8'h80);
    bus_debug = 1'b1;
    rd(14'h00D0);
    check(16'(seen_strobe), 16'h0000);
    check(16'(rd_data), 16'h0000);
    rdc(14'h0030, 8'h0C);
    bus_debug = 1'b0;
    rdc(14'h00D0, 8'h00);
    @(negedge mclk);
    dbg_pe_wr = 1'b1;
    @(negedge mclk);
    dbg_pe_wr = 1'b0;
    rdc(14'h00D0, 8'h2C);
    $display("test secure debug done");
    end_of_test();
  end
endmodule
